// [inc/srcr_pkg.sv]
/*
 * Constants, field layouts, reset values and types for the per-setup
 * rate and calibration register bank.
 * Assumes a 250 MHz pclk and a 32-bit APB register bus.
 */
package srcr_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int unsigned ADDR_W      = 12;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned COEF_W      = 24;
   localparam int unsigned SETUP_W     = 3;
   localparam int unsigned NUM_SETUPS  = 8;
   localparam int unsigned IDX_W       = 8;
   localparam int unsigned RATE_CODE_W = 5;
   localparam int unsigned ORDER_W     = 2;
   localparam int unsigned FILTER_W    = 7;
   localparam int unsigned RATE_W      = 32;
   localparam int unsigned ACC_W       = 40;

   // ************************************************************
   // Register indices (byte address is four times the index)
   // ************************************************************
   localparam logic [7:0] IDX_FILTER_BASE = 8'h20;
   localparam logic [7:0] IDX_ZERO_BASE   = 8'h30;
   localparam logic [7:0] IDX_ZERO_LAST   = 8'h37;
   localparam logic [7:0] IDX_FULL_BASE   = 8'h38;
   localparam logic [7:0] IDX_FULL_LAST   = 8'h3F;
   localparam logic [7:0] IDX_RATE_BASE   = 8'h40;

   // ************************************************************
   // Filter configuration fields
   // ************************************************************
   localparam int unsigned RATE_CODE_LSB = 0;
   localparam int unsigned ORDER_LSB     = 5;
   localparam logic [1:0]  ORDER_DEFAULT = 2'h0;
   localparam logic [1:0]  ORDER_SINC3   = 2'h3;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [6:0]  FILTER_RESET      = 7'h00;
   localparam logic [23:0] ZERO_RESET        = 24'h80_0000;
   localparam logic [3:0]  FULL_RESET_HI     = 4'h5;
   localparam logic [3:0]  FULL_RESET_LO     = 4'h0;
   localparam logic [15:0] FULL_TRIM_DEFAULT = 16'h0000;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam logic [39:0] CLK_FREQ_HZ  = 40'h00_0EE6_B280;
   localparam logic [39:0] MSPS_PER_SPS = 40'h00_0000_03E8;
   localparam logic [39:0] ACC_MODULUS  = CLK_FREQ_HZ * MSPS_PER_SPS;

   // ************************************************************
   // Bus phase tracking
   // ************************************************************
   typedef enum logic [1:0] {
      APB_IDLE   = 2'b01,
      APB_ACCESS = 2'b10
   } srcr_apb_state_t;

endpackage : srcr_pkg

// [design/srcr_rate_decode.sv]
/*
 * Decodes a setup's output rate code and filter order into the output
 * rate in thousandths of a sample per second.
 * Assumes the package srcr_pkg; purely combinational.
 */
`timescale 1ns/1ns
module srcr_rate_decode (
   input  wire logic [4:0]  rate_code,
   input  wire logic [1:0]  order_sel,
   output logic      [31:0] rate_msps
);

   // ************************************************************
   // Rate table
   // ************************************************************
   // Codes 10101 and above all decode as the slowest rate, 2.5 SPS.
   function automatic logic [31:0] rate_lookup(input logic [4:0] code,
                                               input logic       sinc3);
      case (code)
         5'h00, 5'h01: rate_lookup = 32'h0773_5940;
         5'h02, 5'h03: rate_lookup = 32'h03B9_ACA0;
         5'h04:        rate_lookup = 32'h01DC_D650;
         5'h05:        rate_lookup = 32'h017D_7840;
         5'h06:        rate_lookup = 32'h00EE_6B28;
         5'h07:        rate_lookup = sinc3 ? 32'h009E_F23C
                                           : 32'h009E_89F0;
         5'h08:        rate_lookup = sinc3 ? 32'h004C_4B40
                                           : 32'h004C_33D0;
         5'h09:        rate_lookup = sinc3 ? 32'h0026_25A0
                                           : 32'h0026_1DD0;
         5'h0A:        rate_lookup = 32'h000F_4240;
         5'h0B:        rate_lookup = 32'h0007_A120;
         5'h0C:        rate_lookup = sinc3 ? 32'h0006_1CD8
                                           : 32'h0006_08EC;
         5'h0D:        rate_lookup = 32'h0003_0D40;
         5'h0E:        rate_lookup = 32'h0001_86A0;
         5'h0F:        rate_lookup = 32'h0000_E9DE;
         5'h10:        rate_lookup = sinc3 ? 32'h0000_C350
                                           : 32'h0000_C300;
         5'h11:        rate_lookup = 32'h0000_4E20;
         5'h12:        rate_lookup = 32'h0000_411E;
         5'h13:        rate_lookup = 32'h0000_2710;
         5'h14:        rate_lookup = 32'h0000_1388;
         default:      rate_lookup = 32'h0000_09C4;
      endcase
   endfunction : rate_lookup

   // Only the sinc3 order code switches the table; others use default.
   always_comb begin
      rate_msps = rate_lookup(rate_code,
                              order_sel == srcr_pkg::ORDER_SINC3);
   end

endmodule : srcr_rate_decode

// [design/srcr_apb_slave.sv]
/*
 * APB slave front end: tracks the bus phase, latches read data in the
 * setup cycle and answers with no wait state in the access cycle.
 * Assumes a master that holds its request until pready is sampled high.
 */
`timescale 1ns/1ns
module srcr_apb_slave (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [31:0] reg_rd_data,
   input  wire logic        reg_ok,
   output logic      [7:0]  acc_idx,
   output logic             wr_pulse
);

   srcr_pkg::srcr_apb_state_t state_q;
   logic                      err_q;
   logic [31:0]               prdata_q;
   logic                      aligned;

   assign acc_idx = paddr[9:2];
   assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);

   // ************************************************************
   // Phase tracking and read capture
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q  <= srcr_pkg::APB_IDLE;
         err_q    <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         case (state_q)
            srcr_pkg::APB_IDLE: begin
               if (psel && !penable) begin
                  state_q  <= srcr_pkg::APB_ACCESS;
                  err_q    <= !(aligned && reg_ok);
                  prdata_q <= (aligned && reg_ok && !pwrite) ?
                              reg_rd_data : 32'h0000_0000;
               end
            end
            srcr_pkg::APB_ACCESS: begin
               if (psel && penable) begin
                  state_q <= srcr_pkg::APB_IDLE;
               end
            end
            default: state_q <= srcr_pkg::APB_IDLE;
         endcase
      end
   end

   assign pready   = (state_q == srcr_pkg::APB_ACCESS) && psel && penable;
   assign pslverr  = pready && err_q;
   assign wr_pulse = pready && pwrite && !err_q;
   assign prdata   = prdata_q;

endmodule : srcr_apb_slave

// [design/srcr_regs.sv]
/*
 * Per-setup conversion configuration bank: filter order and output rate
 * code, zero-scale and full-scale calibration coefficients for eight
 * setups, decoded rate readback and a sample tick at the active rate.
 * Assumes APB from a master on pclk and a setup selection that is
 * synchronous to pclk.
 */
//
// Overview of operation
// - Each setup picks default filter (order 00) or sinc3 (order 11).
// - Rate code 00111 gives 10390 SPS default, 10416.7 SPS sinc3.
// - Code 01000 gives 4994/5000 SPS; code 01001 gives 2498/2500 SPS.
// - Rate code 01100 gives 395.5 SPS default, 400.6 SPS sinc3.
// - Rate code 10000 gives 49.92 SPS default, 50 SPS sinc3.
// - Each setup owns a readable, writable 24-bit zero-scale coefficient.
// - Zero-scale registers at 0x30 to 0x37, reset to 0x800000.
// - Each setup owns a readable, writable 24-bit full-scale coefficient.
// - Full-scale registers at 0x38 to 0x3F, reset 0x5XXXX0.
`timescale 1ns/1ns
module srcr_regs #(
   parameter logic [15:0] FULL_TRIM = srcr_pkg::FULL_TRIM_DEFAULT
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [2:0]  active_setup,
   output logic      [23:0] zero_scale_coefficient,
   output logic      [23:0] full_scale_coefficient,
   output logic      [1:0]  filter_order_select,
   output logic      [4:0]  output_rate_code,
   output logic      [31:0] output_rate_msps,
   output logic             sample_tick
);

   // The middle digits of the full-scale reset value are a trim value.
   localparam logic [23:0] FULL_RESET = {srcr_pkg::FULL_RESET_HI,
                                         FULL_TRIM,
                                         srcr_pkg::FULL_RESET_LO};

   // ************************************************************
   // Address decode helpers
   // ************************************************************
   function automatic logic in_filter(input logic [7:0] idx);
      in_filter = (idx[7:3] == srcr_pkg::IDX_FILTER_BASE[7:3]);
   endfunction : in_filter

   function automatic logic in_zero(input logic [7:0] idx);
      in_zero = (idx >= srcr_pkg::IDX_ZERO_BASE) &&
                (idx <= srcr_pkg::IDX_ZERO_LAST);
   endfunction : in_zero

   function automatic logic in_full(input logic [7:0] idx);
      in_full = (idx >= srcr_pkg::IDX_FULL_BASE) &&
                (idx <= srcr_pkg::IDX_FULL_LAST);
   endfunction : in_full

   function automatic logic in_rate(input logic [7:0] idx);
      in_rate = (idx[7:3] == srcr_pkg::IDX_RATE_BASE[7:3]);
   endfunction : in_rate

   // Applies byte strobes to the low three lanes of a coefficient.
   function automatic logic [23:0] merge24(input logic [23:0] old,
                                           input logic [31:0] wdata,
                                           input logic [3:0]  strb);
      merge24 = old;
      for (int b = 0; b < 3; b++) begin
         if (strb[b]) begin
            merge24[b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
   endfunction : merge24

   // ************************************************************
   // Storage
   // ************************************************************
   logic [6:0]  filter_q [8];
   logic [23:0] zero_q   [8];
   logic [23:0] full_q   [8];

   logic [7:0]  acc_idx;
   logic [2:0]  acc_setup;
   logic        wr_pulse;
   logic        reg_ok;
   logic [31:0] reg_rd_data;
   logic [31:0] rd_rate_msps;
   logic [31:0] act_rate_msps;

   assign acc_setup = acc_idx[2:0];

   // ************************************************************
   // Bus front end
   // ************************************************************
   srcr_apb_slave u_apb (
      .pclk        (pclk),
      .presetn     (presetn),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .paddr       (paddr),
      .prdata      (prdata),
      .pready      (pready),
      .pslverr     (pslverr),
      .reg_rd_data (reg_rd_data),
      .reg_ok      (reg_ok),
      .acc_idx     (acc_idx),
      .wr_pulse    (wr_pulse)
   );

   // Rate readback slots are read-only; writes to them are errors.
   always_comb begin
      if (pwrite) begin
         reg_ok = in_filter(acc_idx) || in_zero(acc_idx) ||
                  in_full(acc_idx);
      end else begin
         reg_ok = in_filter(acc_idx) || in_zero(acc_idx) ||
                  in_full(acc_idx) || in_rate(acc_idx);
      end
   end

   // ************************************************************
   // Filter configuration registers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int s = 0; s < 8; s++) begin
            filter_q[s] <= srcr_pkg::FILTER_RESET;
         end
      end else if (wr_pulse && in_filter(acc_idx) && pstrb[0]) begin
         filter_q[acc_setup] <= pwdata[6:0];
      end
   end

   // ************************************************************
   // Zero-scale coefficients
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int s = 0; s < 8; s++) begin
            zero_q[s] <= srcr_pkg::ZERO_RESET;
         end
      end else if (wr_pulse && in_zero(acc_idx)) begin
         zero_q[acc_setup] <= merge24(zero_q[acc_setup],
                                      pwdata, pstrb);
      end
   end

   // ************************************************************
   // Full-scale coefficients
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int s = 0; s < 8; s++) begin
            full_q[s] <= FULL_RESET;
         end
      end else if (wr_pulse && in_full(acc_idx)) begin
         full_q[acc_setup] <= merge24(full_q[acc_setup],
                                      pwdata, pstrb);
      end
   end

   // ************************************************************
   // Read multiplexer
   // ************************************************************
   srcr_rate_decode u_rd_rate (
      .rate_code (filter_q[acc_setup][4:0]),
      .order_sel (filter_q[acc_setup][6:5]),
      .rate_msps (rd_rate_msps)
   );

   always_comb begin
      reg_rd_data = 32'h0000_0000;
      if (in_filter(acc_idx)) begin
         reg_rd_data = {25'h000_0000, filter_q[acc_setup]};
      end else if (in_zero(acc_idx)) begin
         reg_rd_data = {8'h00, zero_q[acc_setup]};
      end else if (in_full(acc_idx)) begin
         reg_rd_data = {8'h00, full_q[acc_setup]};
      end else if (in_rate(acc_idx)) begin
         reg_rd_data = rd_rate_msps;
      end
   end

   // ************************************************************
   // Active setup outputs
   // ************************************************************
   srcr_rate_decode u_act_rate (
      .rate_code (filter_q[active_setup][4:0]),
      .order_sel (filter_q[active_setup][6:5]),
      .rate_msps (act_rate_msps)
   );

   // Each output follows the active setup one edge later, so a switch of
   // setup reaches every output in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zero_scale_coefficient <= srcr_pkg::ZERO_RESET;
      end else begin
         zero_scale_coefficient <= zero_q[active_setup];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         full_scale_coefficient <= FULL_RESET;
      end else begin
         full_scale_coefficient <= full_q[active_setup];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filter_order_select <= srcr_pkg::ORDER_DEFAULT;
      end else begin
         filter_order_select <= filter_q[active_setup][6:5];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_rate_code <= 5'h00;
      end else begin
         output_rate_code <= filter_q[active_setup][4:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_rate_msps <= 32'h0000_0000;
      end else begin
         output_rate_msps <= act_rate_msps;
      end
   end

   // ************************************************************
   // Sample tick generator
   // ************************************************************
   // A phase accumulator adds the rate in milli-SPS every cycle and
   // wraps at the clock rate in milli-Hz, so the tick averages the rate
   // exactly even where the period is not a whole number of cycles.
   logic [39:0] acc_q;
   logic [39:0] acc_sum;
   logic        rate_change;
   logic        acc_wrap;

   assign acc_sum     = acc_q + 40'(output_rate_msps);
   assign rate_change = (act_rate_msps != output_rate_msps);
   assign acc_wrap    = (acc_sum >= srcr_pkg::ACC_MODULUS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= 40'h00_0000_0000;
      end else if (rate_change) begin
         acc_q <= 40'h00_0000_0000;
      end else if (acc_wrap) begin
         acc_q <= acc_sum - srcr_pkg::ACC_MODULUS;
      end else begin
         acc_q <= acc_sum;
      end
   end

   // A rate change restarts the phase and swallows the tick of that cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_tick <= 1'b0;
      end else begin
         sample_tick <= acc_wrap && !rate_change;
      end
   end

endmodule : srcr_regs

// [verification/srcr_regs_assertions.sv]
/*
 * Concurrent checks on the ports of the rate and calibration bank.
 * Assumes one pclk domain with presetn as its asynchronous reset.
 */
`timescale 1ns/1ns
module srcr_regs_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [23:0] zero_scale_coefficient,
   input wire logic [23:0] full_scale_coefficient,
   input wire logic [1:0]  filter_order_select,
   input wire logic [4:0]  output_rate_code,
   input wire logic [31:0] output_rate_msps,
   input wire logic        sample_tick
);
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   wire acc = psel && penable && pready;

   access_ready_a: assert property ((psel && !penable) ##1 (psel && penable)
      |-> pready) else $error("no answer in first access cycle");
   ready_cause_a: assert property (pready |-> psel && penable)
      else $error("pready outside an access cycle");
   err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("refusal without ready or with data");
   misalign_err_a: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
      else $error("unaligned access not refused");
   zero_reset_a: assert property ($rose(presetn) |->
      zero_scale_coefficient == 24'h80_0000) else $error("zero reset wrong");
   full_reset_a: assert property ($rose(presetn) |->
      full_scale_coefficient[23:20] == 4'h5 &&
      full_scale_coefficient[3:0] == 4'h0) else $error("full reset wrong");
   coef_upper_a: assert property (acc && !pwrite && !pslverr &&
      paddr[7:6] == 2'b11 |-> prdata[31:24] == 8'h00)
      else $error("coefficient upper bits not zero");
   sinc3_rate_a: assert property ($stable(output_rate_code) &&
      $stable(filter_order_select) && output_rate_code == 5'h07 &&
      filter_order_select == 2'b11 |-> output_rate_msps == 32'h009E_F23C)
      else $error("sinc3 rate for code 00111 wrong");
   default_rate_a: assert property ($stable(output_rate_code) &&
      $stable(filter_order_select) && output_rate_code == 5'h10 &&
      filter_order_select == 2'b00 |-> output_rate_msps == 32'h0000_C300)
      else $error("default rate for code 10000 wrong");
   tick_gap_a: assert property (sample_tick |=> !sample_tick [*8])
      else $error("sample ticks too close");

   write_c: cover property (acc && pwrite && !pslverr);
   refuse_c: cover property (pslverr);
   tick_c: cover property (sample_tick);
endmodule : srcr_regs_assertions

bind srcr_regs srcr_regs_assertions i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .zero_scale_coefficient(zero_scale_coefficient),
   .full_scale_coefficient(full_scale_coefficient),
   .filter_order_select(filter_order_select),
   .output_rate_code(output_rate_code),
   .output_rate_msps(output_rate_msps), .sample_tick(sample_tick));

// [verification/srcr_host_model.sv]
/*
 * Host side APB master model with one transfer task.
 * Assumes pclk from the bench and a bench watchdog that ends a hung wait.
 */
`timescale 1ns/1ns
module srcr_host_model (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   output logic      [3:0]  pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
   end

   // Pready, read data and the error flag are taken at the rising edge
   // that completes the access; only that answer ends the wait.
   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
      logic ok;
      ok = 1'b0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      pstrb <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      while (!ok) begin
         @(posedge pclk);
         ok = pready;
         rd = prdata;
         err = pslverr;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~wd;
   endtask : xfer
endmodule : srcr_host_model

// [verification/srcr_regs_test.sv]
/*
 * Self-checking bench for the rate and calibration register bank.
 * Assumes the host model drives APB and the bench drives reset and setup.
 */
`timescale 1ns/1ns
module srcr_regs_test;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr, sample_tick;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, output_rate_msps;
   logic [3:0]  pstrb;
   logic [2:0]  active_setup;
   logic [23:0] zero_scale_coefficient, full_scale_coefficient;
   logic [1:0]  filter_order_select;
   logic [4:0]  output_rate_code;
   int          num_errors = 0;
   int          total_checks = 0;
   logic [4:0]  codes [5] = '{5'h07, 5'h08, 5'h09, 5'h0C, 5'h10};
   logic [31:0] rdef [5] = '{32'h009E_89F0, 32'h004C_33D0, 32'h0026_1DD0,
                             32'h0006_08EC, 32'h0000_C300};
   logic [31:0] rs3 [5] = '{32'h009E_F23C, 32'h004C_4B40, 32'h0026_25A0,
                            32'h0006_1CD8, 32'h0000_C350};

   always #2 pclk = ~pclk;

   srcr_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   srcr_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .active_setup(active_setup),
      .zero_scale_coefficient(zero_scale_coefficient),
      .full_scale_coefficient(full_scale_coefficient),
      .filter_order_select(filter_order_select),
      .output_rate_code(output_rate_code),
      .output_rate_msps(output_rate_msps), .sample_tick(sample_tick));

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d,
                         input logic ee);
      logic [31:0] r;
      logic        e;
      i_host.xfer(1'b1, a, d, r, e);
      chk("write error flag", {31'h0, ee}, {31'h0, e});
   endtask : wr_reg

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] m,
                         input logic [31:0] x, input logic ee);
      logic [31:0] r;
      logic        e;
      i_host.xfer(1'b0, a, 32'h0000_0000, r, e);
      chk("read error flag", {31'h0, ee}, {31'h0, e});
      chk("read data", x, r & m);
   endtask : rd_chk

   task automatic see_setup(input int s);
      @(posedge pclk);
      active_setup <= 3'(s);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask : see_setup

   task automatic report_and_stop();
      if (num_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      repeat (50000) @(posedge pclk);
      num_errors++;
      report_and_stop();
   end

   initial begin
      int n;
      logic [1:0] ord;
      logic [31:0] exp_rate;
      presetn = 1'b0;
      active_setup = 3'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int s = 0; s < 8; s++) begin
         rd_chk(12'h0C0 + 12'(4 * s), 32'hFFFF_FFFF, 32'h0080_0000, 0);
         rd_chk(12'h0E0 + 12'(4 * s), 32'h00F0_000F, 32'h0050_0000, 0);
      end
      for (int s = 0; s < 8; s++) begin
         wr_reg(12'h0C0 + 12'(4 * s), 32'hFF12_3400 | 32'(s), 0);
         wr_reg(12'h0E0 + 12'(4 * s), 32'hFFAB_CD00 | 32'(s), 0);
      end
      for (int s = 0; s < 8; s++) begin
         rd_chk(12'h0C0 + 12'(4 * s), 32'hFFFF_FFFF,
                32'h0012_3400 | 32'(s), 0);
         rd_chk(12'h0E0 + 12'(4 * s), 32'hFFFF_FFFF,
                32'h00AB_CD00 | 32'(s), 0);
         see_setup(s);
         chk("zero port", 32'h0012_3400 | 32'(s),
             {8'h00, zero_scale_coefficient});
         chk("full port", 32'h00AB_CD00 | 32'(s),
             {8'h00, full_scale_coefficient});
      end
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(12'h0DC, 32'hFFFF_FFFF, 32'h0080_0000, 0);
      rd_chk(12'h0FC, 32'h00F0_000F, 32'h0050_0000, 0);
      rd_chk(12'h0BC, 32'hFFFF_FFFF, 32'h0000_0000, 1);
      rd_chk(12'h0C2, 32'hFFFF_FFFF, 32'h0000_0000, 1);
      wr_reg(12'h10C, 32'h0000_0001, 1);
      rd_chk(12'h400, 32'hFFFF_FFFF, 32'h0000_0000, 1);
      for (int i = 0; i < 5; i++) begin
         for (int o = 0; o < 2; o++) begin
            ord = (o == 1) ? 2'b11 : 2'b00;
            exp_rate = (o == 1) ? rs3[i] : rdef[i];
            wr_reg(12'h08C, {25'h0, ord, codes[i]}, 0);
            rd_chk(12'h10C, 32'hFFFF_FFFF, exp_rate, 0);
            see_setup(3);
            chk("rate port", exp_rate, output_rate_msps);
            chk("order port", {30'h0, ord},
                {30'h0, filter_order_select});
            chk("code port", {27'h0, codes[i]},
                {27'h0, output_rate_code});
         end
      end
      wr_reg(12'h08C, 32'h0000_0000, 0);
      see_setup(3);
      n = 0;
      repeat (5000) begin
         @(negedge pclk);
         if (sample_tick === 1'b1) n++;
      end
      chk("tick count", 32'h0000_0002, 32'(n));
      report_and_stop();
   end
endmodule : srcr_regs_test
